// File: pkg/accel_ctrl_consts.svh
/*
 Register offsets, field positions and reset values for the power, interrupt and
 output format control bank. Assumes inclusion by bare name from design files.
*/
// Overview of operation
// - chained: activity watched only after inactivity
// - unchained: activity and inactivity run independently
// - chained auto doze: inactivity puts device dozing
// - auto doze: activity wakes, normal rate resumes
// - chain clear: auto doze bit ignored
// - run bit: 0 standby, 1 measure; reset standby
// - doze: no sample-ready irq, no FIFO writes
// - doze: activity only; data still refreshed
// - doze rate 00..11 gives 8,4,2,1 Hz
// - enable bit two never drives a pin
// - ready, level, overrun enables gate pins only
// - route bit 0 pin a, 1 pin b
// - pin is OR of routed enabled sources
// - flags set on event, regardless of enables
// - data reads clear overrun; ready, level once drained
// - flag register read clears motion flags
// - stimulus bit applies electrostatic test force
// - wire mode bit: 1 three-wire, 0 four-wire
// - polarity bit: 0 active high, 1 low
// - alignment bit: 1 left, 0 right justified
// - asleep status reflects automatic doze state
`ifndef ACCEL_CTRL_CONSTS_SVH
`define ACCEL_CTRL_CONSTS_SVH
`define ADDR_POWER_MODE_CONTROL 6'h2D
`define ADDR_IRQ_ENABLE_MASK 6'h2E
`define ADDR_IRQ_PIN_ROUTE 6'h2F
`define ADDR_IRQ_FLAGS 6'h30
`define ADDR_OUTPUT_FORMAT_CONTROL 6'h31
`define ADDR_DATA_FIRST 6'h32
`define ADDR_DATA_LAST 6'h37
`define PWR_CHAIN_BIT 5
`define PWR_AUTO_DOZE_BIT 4
`define PWR_RUN_BIT 3
`define PWR_DOZE_BIT 2
`define PWR_RATE_LSB 0
`define PWR_WMASK 8'h3F
`define FMT_STIM_BIT 7
`define FMT_WIRE_BIT 6
`define FMT_POL_BIT 5
`define FMT_ALIGN_BIT 2
`define FMT_WMASK 8'hE4
`define FMT_FIXED_ONES 8'h0B
`define IRQ_WMASK 8'hFB
`define IRQ_READY_BIT 7
`define IRQ_ACT_BIT 4
`define IRQ_STILL_BIT 3
`define IRQ_DATA_CLR_MASK 8'h83
`define IRQ_MOTION_MASK 8'h78
`define CLK_HZ 40000000
`define DOZE_BASE_HZ 8
`define RESET_BYTE 8'h00
`endif

// File: pkg/accel_ctrl_pkg.sv
/*
 Types shared by the control bank files. No assumptions beyond a SystemVerilog tool.
*/
package accel_ctrl_pkg;
   typedef enum logic [1:0] {
      DET_BOTH = 2'b00,
      DET_WAIT_STILL = 2'b01,
      DET_WAIT_ACT = 2'b10
   } detect_state_t;
endpackage : accel_ctrl_pkg

// File: hdl/doze_tick_gen.sv
/*
 Doze sampling tick: one-cycle pulse at 8, 4, 2 or 1 Hz picked by a two-bit code.
 Assumes ref_clk at the rate named in the constants header.
*/
`timescale 1ns/1ps
`include "accel_ctrl_consts.svh"
module doze_tick_gen #(
   parameter int unsigned CLK_HZ = `CLK_HZ,
   parameter int unsigned BASE_HZ = `DOZE_BASE_HZ
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // control
   input wire logic run,
   input wire logic [1:0] rate_code,
   // tick out
   output logic tick
);
   localparam int unsigned BASE_CYC = CLK_HZ / BASE_HZ;
   logic [31:0] cnt_r;
   logic [31:0] limit;

   // 00 fastest; each step doubles the period
   assign limit = (32'(BASE_CYC) << rate_code) - 32'h1;

   // free counter restarts when not running so first tick has full period
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_r >= limit) begin
         cnt_r <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule : doze_tick_gen

// File: hdl/sync2.sv
/*
 Two-flop synchroniser for a vector of levels from outside the clock domain.
 Assumes inputs are quasi-static or independently sampled bits.
*/
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : sync2

// File: hdl/accel_power_irq_format_ctrl.sv
/*
 Power, interrupt and output format control bank of a three-axis accelerometer.
 Registers sit behind a byte-wide register port from the serial interface logic,
 all on ref_clk. Detection engines, FIFO and data path are outside; their event
 pulses arrive on the same clock. The two interrupt pins are pad inputs to the
 system, driven here straight from flops.
*/
`timescale 1ns/1ps
`include "accel_ctrl_consts.svh"
module accel_power_irq_format_ctrl #(
   parameter int unsigned CLK_HZ = `CLK_HZ
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port from the serial interface
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // event pulses from detection, data and FIFO logic
   input wire logic ev_ready,
   input wire logic ev_shock1,
   input wire logic ev_shock2,
   input wire logic ev_act,
   input wire logic ev_still,
   input wire logic ev_level,
   input wire logic ev_overrun,
   input wire logic ready_pending,
   input wire logic level_pending,
   input wire logic act_axes_on,
   input wire logic still_axes_on,
   // controls to the measurement core
   output logic measure_en,
   output logic act_detect_en,
   output logic still_detect_en,
   output logic dozing,
   output logic fifo_write_en,
   output logic sample_tick_doze,
   output logic rate_use_config,
   output logic stimulus_en,
   output logic three_wire_en,
   output logic left_align_en,
   output logic asleep_status,
   // interrupt pins
   output logic irq_pin_a,
   output logic irq_pin_b
);
   logic [7:0] pwr_r;
   logic [7:0] ena_r;
   logic [7:0] route_r;
   logic [7:0] flags_r;
   logic [7:0] fmt_r;
   logic auto_doze_r;
   accel_ctrl_pkg::detect_state_t det_r;
   accel_ctrl_pkg::detect_state_t det_nxt;
   logic [7:0] ev_vec;
   logic [7:0] clr_vec;
   logic [7:0] hold_vec;
   logic [7:0] live;
   logic chain;
   logic auto_cfg;
   logic doze_now;
   logic data_rd;
   logic flags_rd;
   logic tick_w;
   logic [1:0] strap_q;
   logic [7:0] rd_mux;

   assign chain = pwr_r[`PWR_CHAIN_BIT];
   // auto doze counts only with chaining
   assign auto_cfg = chain & pwr_r[`PWR_AUTO_DOZE_BIT];
   assign doze_now = pwr_r[`PWR_DOZE_BIT] | auto_doze_r;
   // reads with side effects on the flags
   assign data_rd = reg_rd && (reg_addr >= `ADDR_DATA_FIRST) && (reg_addr <= `ADDR_DATA_LAST);
   assign flags_rd = reg_rd && (reg_addr == `ADDR_IRQ_FLAGS);

   // doze sample rate pulse
   doze_tick_gen #(
      .CLK_HZ(CLK_HZ)
   ) u_tick (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .run(doze_now & pwr_r[`PWR_RUN_BIT]),
      .rate_code(pwr_r[`PWR_RATE_LSB +: 2]),
      .tick(tick_w)
   );

   // axis-enable levels may come from another block's domain; sample them safely
   sync2 #(
      .W(2)
   ) u_axes (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .d({act_axes_on, still_axes_on}),
      .q(strap_q)
   );

   // power register; run bit clear after reset keeps the device in standby
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_r <= `RESET_BYTE;
      end else if (reg_wr && reg_addr == `ADDR_POWER_MODE_CONTROL) begin
         pwr_r <= reg_wdata & `PWR_WMASK;
      end
   end

   // enable register; bit 2 is unused and reads zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ena_r <= `RESET_BYTE;
      end else if (reg_wr && reg_addr == `ADDR_IRQ_ENABLE_MASK) begin
         ena_r <= reg_wdata & `IRQ_WMASK;
      end
   end

   // routing register; same unused bit as the enables
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         route_r <= `RESET_BYTE;
      end else if (reg_wr && reg_addr == `ADDR_IRQ_PIN_ROUTE) begin
         route_r <= reg_wdata & `IRQ_WMASK;
      end
   end

   // format register; fixed ones are supplied on read only
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fmt_r <= `RESET_BYTE;
      end else if (reg_wr && reg_addr == `ADDR_OUTPUT_FORMAT_CONTROL) begin
         fmt_r <= reg_wdata & `FMT_WMASK;
      end
   end

   // link sequencing of activity and inactivity watching
   always_comb begin
      det_nxt = det_r;
      if (!chain || !(strap_q[1] && strap_q[0])) begin
         det_nxt = accel_ctrl_pkg::DET_BOTH;
      end else begin
         unique case (det_r)
            accel_ctrl_pkg::DET_BOTH: det_nxt = accel_ctrl_pkg::DET_WAIT_STILL;
            accel_ctrl_pkg::DET_WAIT_STILL: begin
               if (ev_still) begin
                  det_nxt = accel_ctrl_pkg::DET_WAIT_ACT;
               end
            end
            accel_ctrl_pkg::DET_WAIT_ACT: begin
               if (ev_act) begin
                  det_nxt = accel_ctrl_pkg::DET_WAIT_STILL;
               end
            end
            default: det_nxt = accel_ctrl_pkg::DET_BOTH;
         endcase
      end
   end

   // link state register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         det_r <= accel_ctrl_pkg::DET_BOTH;
      end else begin
         det_r <= det_nxt;
      end
   end

   // automatic doze: inactivity enters, activity leaves
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         auto_doze_r <= 1'b0;
      end else if (!auto_cfg || !pwr_r[`PWR_RUN_BIT]) begin
         auto_doze_r <= 1'b0;
      end else if (auto_doze_r && ev_act && strap_q[1]) begin
         auto_doze_r <= 1'b0;
      end else if (ev_still && strap_q[0]) begin
         auto_doze_r <= 1'b1;
      end
   end

   // hardware events; unused bit 2 never sets
   assign ev_vec = {ev_ready & ~doze_now, ev_shock1, ev_shock2, ev_act,
                    ev_still, 1'b0, ev_level, ev_overrun};

   // ready and level flags clear on data read only once their source has drained; overrun clears on any data read
   assign hold_vec = {ready_pending, 5'h00, level_pending, 1'b0};
   assign clr_vec = ({8{data_rd}} & `IRQ_DATA_CLR_MASK & ~hold_vec)
                  | ({8{flags_rd}} & `IRQ_MOTION_MASK);

   // sticky flags, set wins over clear, independent of enables
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_r <= `RESET_BYTE;
      end else begin
         flags_r <= (flags_r & ~clr_vec) | ev_vec;
      end
   end

   // pins from flags, mask, routing and polarity every cycle
   assign live = flags_r & ena_r;

   // first pin: enabled sources whose route bit is zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_pin_a <= 1'b0;
      end else begin
         irq_pin_a <= (|(live & ~route_r)) ^ fmt_r[`FMT_POL_BIT];
      end
   end

   // second pin: route bit one; polarity applied after the OR
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_pin_b <= 1'b0;
      end else begin
         irq_pin_b <= (|(live & route_r)) ^ fmt_r[`FMT_POL_BIT];
      end
   end

   // read data select; unmapped addresses read zero
   always_comb begin
      unique case (reg_addr)
         `ADDR_POWER_MODE_CONTROL: rd_mux = pwr_r;
         `ADDR_IRQ_ENABLE_MASK: rd_mux = ena_r;
         `ADDR_IRQ_PIN_ROUTE: rd_mux = route_r;
         `ADDR_IRQ_FLAGS: rd_mux = flags_r;
         `ADDR_OUTPUT_FORMAT_CONTROL: rd_mux = fmt_r | `FMT_FIXED_ONES;
         default: rd_mux = `RESET_BYTE;
      endcase
   end

   // read data, registered; holds until the next read
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= `RESET_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   // measurement follows the run bit; standby out of reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         measure_en <= 1'b0;
      end else begin
         measure_en <= pwr_r[`PWR_RUN_BIT];
      end
   end

   // activity watching: link state gates it, doze keeps it alive
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         act_detect_en <= 1'b0;
      end else begin
         act_detect_en <= pwr_r[`PWR_RUN_BIT] && strap_q[1]
                          && det_nxt != accel_ctrl_pkg::DET_WAIT_STILL;
      end
   end

   // inactivity watching stops in doze and while waiting for activity
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         still_detect_en <= 1'b0;
      end else begin
         still_detect_en <= pwr_r[`PWR_RUN_BIT] && strap_q[0] && !doze_now
                            && det_nxt != accel_ctrl_pkg::DET_WAIT_ACT;
      end
   end

   // doze state seen by the measurement core
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dozing <= 1'b0;
      end else begin
         dozing <= doze_now;
      end
   end

   // no fifo writes in standby or doze
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fifo_write_en <= 1'b0;
      end else begin
         fifo_write_en <= pwr_r[`PWR_RUN_BIT] & ~doze_now;
      end
   end

   // doze sample pulse, one flop later so the port comes from a flop
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sample_tick_doze <= 1'b0;
      end else begin
         sample_tick_doze <= tick_w;
      end
   end

   // configured output rate everywhere but doze
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rate_use_config <= 1'b1;
      end else begin
         rate_use_config <= ~doze_now;
      end
   end

   // test force straight from the format register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stimulus_en <= 1'b0;
      end else begin
         stimulus_en <= fmt_r[`FMT_STIM_BIT];
      end
   end

   // serial wire mode for the interface logic
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         three_wire_en <= 1'b0;
      end else begin
         three_wire_en <= fmt_r[`FMT_WIRE_BIT];
      end
   end

   // data justification for the output data path
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         left_align_en <= 1'b0;
      end else begin
         left_align_en <= fmt_r[`FMT_ALIGN_BIT];
      end
   end

   // asleep tracks automatic doze only; manual doze leaves it low
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         asleep_status <= 1'b0;
      end else begin
         asleep_status <= auto_doze_r;
      end
   end
endmodule : accel_power_irq_format_ctrl

// File: tb/accel_ctrl_checker.sv
/*
 Port-level assertions for the power, interrupt and format control bank.
 Assumes binding onto the bank, all on ref_clk with arst_n low active.
*/
`timescale 1ns/1ps
module accel_ctrl_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // controls
   input wire logic measure_en,
   input wire logic dozing,
   input wire logic fifo_write_en,
   input wire logic rate_use_config,
   input wire logic stimulus_en,
   input wire logic three_wire_en,
   input wire logic left_align_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // decoded strobes; outputs trail a write by two edges
   wire wr2d = reg_wr && reg_addr == 6'h2D;
   wire wr31 = reg_wr && reg_addr == 6'h31;
   wire rd2d = reg_rd && reg_addr == 6'h2D;
   wire rd31 = reg_rd && reg_addr == 6'h31;
   a_stim_follow: assert property (wr31 |=> ##1 stimulus_en == $past(reg_wdata[7], 2))
      else $error("test force does not follow format write");
   a_wire_follow: assert property (wr31 |=> ##1 three_wire_en == $past(reg_wdata[6], 2))
      else $error("wire mode does not follow format write");
   a_align_follow: assert property (wr31 |-> ##2 left_align_en == $past(reg_wdata[2], 2))
      else $error("alignment does not follow format write");
   a_run_follow: assert property (wr2d |=> ##1 measure_en == $past(reg_wdata[3], 2))
      else $error("measure enable does not follow run bit");
   a_fmt_fixed: assert property (rd31 |=> (reg_rdata & 8'h1B) == 8'h0B)
      else $error("format fixed bits read wrong");
   a_pwr_top: assert property (rd2d |=> reg_rdata[7:6] == 2'b00)
      else $error("power register top bits not zero");
   a_doze_nofifo: assert property (dozing |-> !fifo_write_en)
      else $error("fifo written while dozing");
   a_doze_rate: assert property (rate_use_config != dozing)
      else $error("configured rate used while dozing");
   a_doze_manual: assert property (wr2d && reg_wdata[2] |=> ##1 dozing)
      else $error("doze bit does not reach doze state");
endmodule : accel_ctrl_checker
bind accel_power_irq_format_ctrl accel_ctrl_checker chk (.*);

// File: tb/host_bus_model.sv
/*
 Host side of the byte register port: one-cycle strobes driven at falling edges.
 Assumes the bank samples on rising edges and answers a read one edge later.
*/
`timescale 1ns/1ps
module host_bus_model (
   // clock
   input wire logic ref_clk,
   // register port
   output logic [5:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // address and data scrambled after release so stale values never help
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
   endtask : wr
   // read data taken after the sampling edge has landed
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      v = reg_rdata;
   endtask : rd
endmodule : host_bus_model

// File: tb/accel_power_irq_format_ctrl_tb_top.sv
/*
 Self-checking bench: reset values, format bits, routing, masking, doze.
 Assumes host model and checker are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module accel_power_irq_format_ctrl_tb_top;
   // stimulus and observed pins
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] ev = 8'h00;
   logic act_on = 1'b0;
   logic still_on = 1'b0;
   logic rdy_pend = 1'b0;
   logic lvl_pend = 1'b0;
   logic [5:0] reg_addr;
   logic reg_wr, reg_rd;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic meas, act_en, still_en, dozing, fifo_wr, tick, rate_cfg, stim, wire3, align;
   logic asleep, pin_a, pin_b;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int ticks = 0;
   // short doze period: 100 cycles at code 00
   accel_power_irq_format_ctrl #(.CLK_HZ(800)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .ev_ready(ev[7]), .ev_shock1(ev[6]), .ev_shock2(ev[5]),
      .ev_act(ev[4]), .ev_still(ev[3]), .ev_level(ev[1]), .ev_overrun(ev[0]),
      .ready_pending(rdy_pend), .level_pending(lvl_pend), .act_axes_on(act_on),
      .still_axes_on(still_on), .measure_en(meas), .act_detect_en(act_en),
      .still_detect_en(still_en), .dozing(dozing), .fifo_write_en(fifo_wr),
      .sample_tick_doze(tick), .rate_use_config(rate_cfg), .stimulus_en(stim),
      .three_wire_en(wire3), .left_align_en(align), .asleep_status(asleep),
      .irq_pin_a(pin_a), .irq_pin_b(pin_b));
   host_bus_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   always #12.5 ref_clk = ~ref_clk;
   // cycle ceiling and doze tick count; run needs about 3000 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (tick === 1'b1) ticks++;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle
   task automatic pulse(input logic [7:0] m);
      @(negedge ref_clk);
      ev = m;
      @(negedge ref_clk);
      ev = 8'h00;
   endtask : pulse
   task automatic t_reset();
      logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0B};
      for (int i = 0; i < 5; i++) begin
         host.rd(6'h2D + 6'(i), d);
         `CHK("reset reg", exp[i], d)
      end
      `CHK("standby", 4'b0100, {meas, rate_cfg, pin_a, pin_b})
   endtask : t_reset
   task automatic t_format();
      host.wr(6'h31, 8'hFF);
      idle(2);
      `CHK("format on", 5'h1F, {stim, wire3, align, pin_a, pin_b})
      host.rd(6'h31, d);
      `CHK("format read", 8'hEF, d)
      host.wr(6'h31, 8'h00);
      idle(2);
      `CHK("format off", 5'h00, {stim, wire3, align, pin_a, pin_b})
   endtask : t_format
   task automatic t_route();
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         if (i == 2) continue;
         r = (i % 2) ? 8'h01 << i : 8'h00;
         host.wr(6'h2F, r);
         host.wr(6'h2E, 8'h01 << i);
         pulse(8'h01 << i);
         idle(3);
         `CHK("pins", {|r, ~|r}, {pin_b, pin_a})
         host.rd(6'h30, d);
         `CHK("flag", 8'h01 << i, d & 8'hFB)
         host.rd(6'h32, d);
         idle(3);
         `CHK("pins cleared", 2'b00, {pin_b, pin_a})
      end
      host.wr(6'h2E, 8'h00);
   endtask : t_route
   task automatic t_masked();
      pulse(8'hFB);
      idle(3);
      `CHK("masked pins", 2'b00, {pin_b, pin_a})
      host.rd(6'h30, d);
      `CHK("flags set", 8'hFB, d & 8'hFB)
      host.rd(6'h32, d);
      host.rd(6'h30, d);
      `CHK("flags clear", 8'h00, d & 8'hFB)
      rdy_pend = 1'b1;
      lvl_pend = 1'b1;
      pulse(8'h83);
      host.rd(6'h32, d);
      host.rd(6'h30, d);
      `CHK("held flags", 8'h82, d & 8'hFB)
      rdy_pend = 1'b0;
      lvl_pend = 1'b0;
      host.rd(6'h32, d);
      host.rd(6'h30, d);
      `CHK("drained flags", 8'h00, d & 8'hFB)
   endtask : t_masked
   task automatic t_doze();
      act_on = 1'b1;
      still_on = 1'b1;
      idle(3);
      host.wr(6'h2D, 8'h38);
      idle(2);
      `CHK("chain wait", 2'b01, {act_en, still_en})
      pulse(8'h08);
      idle(3);
      `CHK("auto doze", 6'b110010, {dozing, asleep, fifo_wr, rate_cfg, act_en, still_en})
      ticks = 0;
      idle(400);
      `CHK("8 Hz ticks", 4, ticks)
      host.wr(6'h2D, 8'h39);
      idle(2);
      ticks = 0;
      idle(800);
      `CHK("4 Hz ticks", 4, ticks)
      host.wr(6'h2D, 8'h3A);
      idle(2);
      ticks = 0;
      idle(800);
      `CHK("2 Hz ticks", 2, ticks)
      host.wr(6'h2D, 8'h3B);
      idle(2);
      ticks = 0;
      idle(800);
      `CHK("1 Hz ticks", 1, ticks)
      pulse(8'h10);
      idle(3);
      `CHK("wake", 6'b001101, {dozing, asleep, fifo_wr, rate_cfg, act_en, still_en})
      host.wr(6'h2D, 8'h00);
      host.wr(6'h2D, 8'h18);
      idle(2);
      `CHK("no chain", 2'b11, {act_en, still_en})
      pulse(8'h08);
      idle(3);
      `CHK("no auto doze", 2'b00, {dozing, asleep})
      host.wr(6'h2D, 8'h00);
      host.wr(6'h2D, 8'h0C);
      idle(2);
      `CHK("manual doze", 3'b100, {dozing, fifo_wr, asleep})
      pulse(8'h80);
      idle(3);
      host.rd(6'h30, d);
      `CHK("ready held off", 1'b0, d[7])
      host.wr(6'h2D, 8'h00);
   endtask : t_doze
   initial begin
      repeat (12) @(negedge ref_clk);
      arst_n = 1'b1;
      t_reset();
      t_format();
      t_route();
      t_masked();
      t_doze();
      final_report();
   end
endmodule : accel_power_irq_format_ctrl_tb_top
